// ==== hdl/xpt_pkg.sv ====
// Purpose: Shared constants and slot helpers for the crosspoint programming link
// Assumes: 16 outputs, 5-bit slot per output (4 source bits, 1 enable bit)
// Notes:   Slot k sits at word bits [5k+4:5k]; slot bit i is data bit Di
package xpt_pkg;
	localparam int NUM_OUT = 16;
	localparam int SEL_W   = 4;
	localparam int SLOT_W  = 5;
	localparam int ADDR_W  = 4;
	localparam int WORD_W  = NUM_OUT * SLOT_W;
	localparam int EN_BIT  = 4;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS        = 25;
	localparam int PCLK_HALF_NS  = 100;
	localparam int UPD_LOW_NS    = 100;
	localparam int PCLK_HALF_CYC = (PCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int UPD_LOW_CYC   = (UPD_LOW_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------
	// Controller register map
	// ----------------------------------------
	localparam int          REG_AW     = 8;
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_PAR    = 8'h08;
	localparam logic [7:0]  REG_DEV    = 8'h0C;
	localparam logic [7:0]  REG_DATA0  = 8'h10;
	localparam logic [7:0]  REG_DATA1  = 8'h14;
	localparam logic [7:0]  REG_DATA2  = 8'h18;
	localparam int CTL_SERIAL  = 0;
	localparam int CTL_PAR     = 1;
	localparam int CTL_UPDATE  = 2;
	localparam int CTL_RELEASE = 3;
	localparam int CTL_AUTOUPD = 4;
	localparam int ST_BUSY     = 0;
	localparam int ST_LOADED   = 1;
	localparam int PAR_DATA_LSB = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	function automatic logic [SLOT_W-1:0] get_slot(input logic [WORD_W-1:0] w,
		input logic [ADDR_W-1:0] a);
		get_slot = w[a*SLOT_W +: SLOT_W];
	endfunction

	function automatic logic [WORD_W-1:0] put_slot(input logic [WORD_W-1:0] w,
		input logic [ADDR_W-1:0] a, input logic [SLOT_W-1:0] d);
		logic [WORD_W-1:0] r;
		r = w;
		r[a*SLOT_W +: SLOT_W] = d;
		put_slot = r;
	endfunction
endpackage

// ==== hdl/xpt_if.sv ====
// Purpose: Programming pins between controller and crosspoint device
// Assumes: All pins are plain one-way logic levels
// Notes:   Chains need one instance per hop (data_out to next data_in)
`timescale 1ns/100ps
interface xpt_if;
	import xpt_pkg::*;
	logic                load_mode_select;
	logic                chip_sel_n;
	logic                update_n;
	logic                prog_clk;
	logic                data_in;
	logic                data_out;
	logic                matrix_reset_n;
	logic [ADDR_W-1:0]   output_address;
	logic [SLOT_W-1:0]   slot_data;

	modport dev (
		input  load_mode_select, chip_sel_n, update_n, prog_clk, data_in,
		input  matrix_reset_n, output_address, slot_data,
		output data_out
	);
	modport host (
		output load_mode_select, chip_sel_n, update_n, prog_clk, data_in,
		output matrix_reset_n, output_address, slot_data,
		input  data_out
	);
endinterface

// ==== hdl/xpt_dev.sv ====
// Purpose: Crosspoint programming logic: shift register, update latch, output decode
// Assumes: All input pins are asynchronous to clk_sys and are resynchronised here
// Notes:   Update latch is emulated synchronously; it follows the shift register
//          every cycle while chip select and update are both low
`timescale 1ns/100ps
module xpt_dev #(
	parameter logic [xpt_pkg::WORD_W-1:0] SR_INIT = {xpt_pkg::NUM_OUT{5'h15}}
) (
	input  wire logic                                          clk_sys,
	input  wire logic                                          resetn,
	input  wire logic                                          clk_en,
	xpt_if.dev                                                 pins,
	output logic [xpt_pkg::NUM_OUT*xpt_pkg::SEL_W-1:0]         out_select,
	output logic [xpt_pkg::NUM_OUT-1:0]                        out_enable
);
	import xpt_pkg::*;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	localparam int SYN_W = 6 + ADDR_W + SLOT_W;
	// Idle levels: clock high, select/update high, reset pin asserted
	localparam logic [SYN_W-1:0] SYN_RST = {6'b101100, {ADDR_W{1'b0}}, {SLOT_W{1'b0}}};

	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	wire  [SYN_W-1:0] pin_raw;

	assign pin_raw = {pins.prog_clk, pins.data_in, pins.chip_sel_n, pins.update_n,
		pins.load_mode_select, pins.matrix_reset_n, pins.output_address, pins.slot_data};

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			syn1_q <= SYN_RST;
			syn2_q <= SYN_RST;
		end else if (clk_en) begin
			syn1_q <= pin_raw;
			syn2_q <= syn1_q;
		end
	end

	wire                s_clk;
	wire                s_din;
	wire                s_cs_n;
	wire                s_upd_n;
	wire                s_mode;
	wire                s_rst_n;
	wire [ADDR_W-1:0]   s_addr;
	wire [SLOT_W-1:0]   s_data;

	assign {s_clk, s_din, s_cs_n, s_upd_n, s_mode, s_rst_n, s_addr, s_data} = syn2_q;

	// ----------------------------------------
	// Edge detect and decode
	// ----------------------------------------
	logic clk_prev_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			clk_prev_q <= 1'b1;
		end else if (clk_en) begin
			clk_prev_q <= s_clk;
		end
	end

	wire clk_fall;
	wire sel;
	wire shift_en;
	wire par_en;
	wire xfer;

	assign clk_fall = clk_prev_q & ~s_clk;
	assign sel      = ~s_cs_n;
	assign shift_en = clk_fall & sel & ~s_mode;
	assign par_en   = clk_fall & sel & s_mode;
	assign xfer     = sel & ~s_upd_n;

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	// No clear from the reset pin: contents survive it and start as an
	// arbitrary pattern, so the host must load every slot before updating.
	logic [WORD_W-1:0] sr_q;
	wire  [WORD_W-1:0] sr_shift;
	wire  [WORD_W-1:0] sr_par;
	wire  [SLOT_W-1:0] rev_data;

	// Serial slots arrive D0 first, so bit order inside a slot is reversed
	// on the wire; the parallel path reverses to match.
	genvar gi;
	generate
		for (gi = 0; gi < SLOT_W; gi++) begin : g_rev
			assign rev_data[gi] = s_data[SLOT_W-1-gi];
		end
	endgenerate

	assign sr_shift = {sr_q[WORD_W-2:0], s_din};
	assign sr_par   = put_slot(sr_q, s_addr, rev_data);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sr_q <= SR_INIT;
		end else if (clk_en) begin
			if (shift_en) begin
				sr_q <= sr_shift;
			end else if (par_en) begin
				sr_q <= sr_par;
			end
		end
	end

	// Last bit of the word leaves first, ready for the next device
	assign pins.data_out = sr_q[WORD_W-1];

	// ----------------------------------------
	// Update latch
	// ----------------------------------------
	logic [WORD_W-1:0] mat_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mat_q <= '0;
		end else if (clk_en) begin
			if (xfer) begin
				mat_q <= sr_q;
			end
		end
	end

	// ----------------------------------------
	// Output decode
	// ----------------------------------------
	// Stored slot bit 4 is D0 and bit 0 is D4 (enable).
	wire [NUM_OUT*SEL_W-1:0] sel_d;
	wire [NUM_OUT-1:0]       en_d;

	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			wire [SLOT_W-1:0] slot;
			assign slot = get_slot(mat_q, ADDR_W'(gi));
			assign sel_d[gi*SEL_W +: SEL_W] = {slot[1], slot[2], slot[3], slot[4]};
			// Reset pin gates only the enables; no register is cleared
			assign en_d[gi] = slot[0] & s_rst_n;
		end
	endgenerate

	logic [NUM_OUT*SEL_W-1:0] out_select_q;
	logic [NUM_OUT-1:0]       out_enable_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			out_select_q <= '0;
			out_enable_q <= '0;
		end else if (clk_en) begin
			out_select_q <= sel_d;
			out_enable_q <= en_d;
		end
	end

	assign out_select = out_select_q;
	assign out_enable = out_enable_q;
endmodule

// ==== hdl/xpt_host.sv ====
// Purpose: Controller that drives the crosspoint programming pins from registers
// Assumes: Single-cycle register port; programming clock divided from clk_sys
// Notes:   Update is refused until every slot has been loaded once
//
// Function
// - Serial pass loads full 80-bit word
// - Mode select low means serial loading
// - Accept clocked data only while selected
// - Sample serial input on clock falling edge
// - Slot: four source bits, enable bit
// - Host sends highest output slot first
// - Host keeps update high while shifting
// - Latch transparent while update, select low
// - Serial out feeds next chained device
// - Chain: last device first, 80 each
// - Parallel: mode high, update high, clock high
// - Host presents address and slot data
// - Parallel falling edge loads addressed slot
// - Several slots load, one update applies
// - Reset pin only disables every output
// - Power-up register contents are arbitrary
// - Host programs all outputs after power-up
// - Select and update low transfer shift register
// - Host avoids update before full load
`timescale 1ns/100ps
module xpt_host #(
	parameter int CHAIN_LEN = 1,
	parameter int HALF_CYC  = xpt_pkg::PCLK_HALF_CYC,
	parameter int UPD_CYC   = xpt_pkg::UPD_LOW_CYC
) (
	input  wire logic                         clk_sys,
	input  wire logic                         resetn,
	input  wire logic                         clk_en,
	xpt_if.host                               pins,
	input  wire logic [xpt_pkg::REG_AW-1:0]   addr,
	input  wire logic [31:0]                  wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic      [31:0]                  rdata
);
	import xpt_pkg::*;

	typedef enum logic [2:0] {
		XH_IDLE  = 3'h0,
		XH_SETUP = 3'h1,
		XH_LOW   = 3'h3,
		XH_TAIL  = 3'h2,
		XH_UPD   = 3'h6
	} xph_state_e;

	localparam int DW = (CHAIN_LEN > 1) ? $clog2(CHAIN_LEN) : 1;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [WORD_W-1:0]    mem_q [CHAIN_LEN];
	logic [DW-1:0]        dev_sel_q;
	logic [ADDR_W-1:0]    par_addr_q;
	logic [SLOT_W-1:0]    par_data_q;
	logic                 release_q;
	logic                 autoupd_q;
	logic [NUM_OUT-1:0]   loaded_q;
	logic [31:0]          rdata_q;

	wire w_ctrl = wr & (addr == REG_CTRL);
	wire w_par  = wr & (addr == REG_PAR);
	wire w_dev  = wr & (addr == REG_DEV);
	wire w_d0   = wr & (addr == REG_DATA0);
	wire w_d1   = wr & (addr == REG_DATA1);
	wire w_d2   = wr & (addr == REG_DATA2);

	xph_state_e state_q;
	wire        idle     = (state_q == XH_IDLE);
	wire        loaded   = &loaded_q;
	wire        go_ser   = w_ctrl & wdata[CTL_SERIAL] & idle;
	wire        go_par   = w_ctrl & wdata[CTL_PAR] & idle & ~go_ser;
	// Transfer of an unloaded shift register would apply random settings
	wire        go_upd   = w_ctrl & wdata[CTL_UPDATE] & idle & ~go_ser & ~go_par & loaded;

	wire [WORD_W-1:0] cur_word = mem_q[dev_sel_q];
	wire [31:0] rd_mux =
		(addr == REG_CTRL)   ? {27'h0, autoupd_q, release_q, 3'h0} :
		(addr == REG_STATUS) ? {30'h0, loaded, ~idle} :
		(addr == REG_PAR)    ? {23'h0, par_data_q, par_addr_q} :
		(addr == REG_DEV)    ? 32'(dev_sel_q) :
		(addr == REG_DATA0)  ? cur_word[31:0] :
		(addr == REG_DATA1)  ? cur_word[63:32] :
		(addr == REG_DATA2)  ? {16'h0, cur_word[79:64]} : 32'h0;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < CHAIN_LEN; i++) begin
				mem_q[i] <= '0;
			end
			dev_sel_q  <= '0;
			par_addr_q <= '0;
			par_data_q <= '0;
			release_q  <= CTRL_RST[CTL_RELEASE];
			autoupd_q  <= CTRL_RST[CTL_AUTOUPD];
			rdata_q    <= '0;
		end else if (clk_en) begin
			rdata_q <= rd ? rd_mux : 32'h0;
			if (w_ctrl) begin
				release_q <= wdata[CTL_RELEASE];
				autoupd_q <= wdata[CTL_AUTOUPD];
			end
			if (w_par) begin
				par_addr_q <= wdata[ADDR_W-1:0];
				par_data_q <= wdata[PAR_DATA_LSB +: SLOT_W];
			end
			if (w_dev) begin
				dev_sel_q <= wdata[DW-1:0];
			end
			if (w_d0) begin
				mem_q[dev_sel_q][31:0] <= wdata;
			end
			if (w_d1) begin
				mem_q[dev_sel_q][63:32] <= wdata;
			end
			if (w_d2) begin
				mem_q[dev_sel_q][79:64] <= wdata[15:0];
			end
		end
	end

	assign rdata = rdata_q;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic [15:0]          cnt_q;
	logic [DW-1:0]        dev_q;
	logic [ADDR_W-1:0]    slot_q;
	logic [2:0]           bit_q;
	logic                 serial_q;
	logic                 doupd_q;
	logic                 clk_q;
	logic                 cs_n_q;
	logic                 upd_n_q;
	logic                 mode_q;
	logic                 din_q;

	wire cnt_done = (cnt_q == 16'(HALF_CYC - 1));
	wire upd_done = (cnt_q == 16'(UPD_CYC - 1));
	wire last_bit = ~serial_q | ((dev_q == '0) & (slot_q == '0) & (bit_q == 3'(SLOT_W - 1)));
	wire [SLOT_W-1:0] tx_slot = get_slot(mem_q[dev_q], slot_q);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q  <= XH_IDLE;
			cnt_q    <= '0;
			dev_q    <= '0;
			slot_q   <= '0;
			bit_q    <= '0;
			serial_q <= 1'b0;
			doupd_q  <= 1'b0;
			clk_q    <= 1'b1;
			cs_n_q   <= 1'b1;
			upd_n_q  <= 1'b1;
			mode_q   <= 1'b0;
			din_q    <= 1'b0;
			loaded_q <= '0;
		end else if (clk_en) begin
			cnt_q <= cnt_q + 16'h0001;
			case (state_q)
				XH_IDLE: begin
					cnt_q <= '0;
					if (go_ser) begin
						state_q  <= XH_SETUP;
						serial_q <= 1'b1;
						doupd_q  <= autoupd_q;
						mode_q   <= 1'b0;
						cs_n_q   <= 1'b0;
						dev_q    <= DW'(CHAIN_LEN - 1);
						slot_q   <= ADDR_W'(NUM_OUT - 1);
						bit_q    <= '0;
					end else if (go_par) begin
						state_q  <= XH_SETUP;
						serial_q <= 1'b0;
						doupd_q  <= autoupd_q & (loaded_q == ~({{(NUM_OUT-1){1'b0}}, 1'b1} << par_addr_q));
						mode_q   <= 1'b1;
						cs_n_q   <= 1'b0;
					end else if (go_upd) begin
						state_q <= XH_UPD;
						cs_n_q  <= 1'b0;
						upd_n_q <= 1'b0;
					end
				end
				XH_SETUP: begin
					// Clock high, update high, data set up before the fall
					din_q <= tx_slot[bit_q];
					if (cnt_done) begin
						state_q <= XH_LOW;
						clk_q   <= 1'b0;
						cnt_q   <= '0;
					end
				end
				XH_LOW: begin
					if (cnt_done) begin
						clk_q <= 1'b1;
						cnt_q <= '0;
						if (last_bit) begin
							state_q <= XH_TAIL;
						end else begin
							state_q <= XH_SETUP;
							if (bit_q == 3'(SLOT_W - 1)) begin
								bit_q  <= '0;
								slot_q <= slot_q - 1'b1;
								if (slot_q == '0) begin
									dev_q <= dev_q - 1'b1;
								end
							end else begin
								bit_q <= bit_q + 3'h1;
							end
						end
					end
				end
				XH_TAIL: begin
					if (cnt_done) begin
						cnt_q <= '0;
						if (serial_q) begin
							loaded_q <= '1;
						end else begin
							loaded_q[par_addr_q] <= 1'b1;
						end
						if (doupd_q | (autoupd_q & serial_q)) begin
							state_q <= XH_UPD;
							upd_n_q <= 1'b0;
						end else begin
							state_q <= XH_IDLE;
							cs_n_q  <= 1'b1;
						end
					end
				end
				XH_UPD: begin
					if (upd_done) begin
						state_q <= XH_IDLE;
						upd_n_q <= 1'b1;
						cs_n_q  <= 1'b1;
					end
				end
				default: begin
					state_q <= XH_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	assign pins.prog_clk         = clk_q;
	assign pins.chip_sel_n       = cs_n_q;
	assign pins.update_n         = upd_n_q;
	assign pins.load_mode_select = mode_q;
	assign pins.data_in          = din_q;
	assign pins.output_address   = par_addr_q;
	assign pins.slot_data        = par_data_q;
	assign pins.matrix_reset_n   = release_q;
endmodule

// ==== bench/xpt_link_monitor.sv ====
// Purpose: Protocol checks on the programming link between controller and device
// Assumes: Default link timing, one clock domain
// Notes:   Watches the pins only; device outputs are judged by the bench
`timescale 1ns/100ps
module xpt_link_monitor #(
	parameter int CHAIN_LEN = 1
) (
	input wire logic                       clk_sys,
	input wire logic                       resetn,
	input wire logic                       load_mode_select,
	input wire logic                       chip_sel_n,
	input wire logic                       update_n,
	input wire logic                       prog_clk,
	input wire logic                       data_in,
	input wire logic                       data_out,
	input wire logic [xpt_pkg::ADDR_W-1:0] output_address,
	input wire logic [xpt_pkg::SLOT_W-1:0] slot_data
);
	import xpt_pkg::*;
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic               clk_prev_q;
	logic [11:0]        falls_q;
	logic [11:0]        falls_d;
	logic [2:0]         since_q;
	logic [2:0]         since_d;
	logic [NUM_OUT-1:0] loaded_q;
	logic [NUM_OUT-1:0] loaded_d;
	logic               fall_w;
	logic               ser_done_w;
	assign fall_w     = clk_prev_q & ~prog_clk & ~chip_sel_n;
	assign ser_done_w = fall_w & ~load_mode_select & (falls_q == 12'(WORD_W * CHAIN_LEN - 1));
	assign falls_d    = chip_sel_n ? 12'h000 : falls_q + 12'(fall_w);
	assign since_d    = fall_w ? 3'h0 : (since_q == 3'h7) ? since_q : since_q + 3'h1;
	// Loaded tracking mirrors what the device really holds, so early updates are caught
	assign loaded_d   = ser_done_w ? '1 : (fall_w & load_mode_select) ?
		(loaded_q | (NUM_OUT'(1) << output_address)) : loaded_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			clk_prev_q <= 1'b1;
			falls_q    <= 12'h000;
			since_q    <= 3'h7;
			loaded_q   <= '0;
		end else begin
			clk_prev_q <= prog_clk;
			falls_q    <= falls_d;
			since_q    <= since_d;
			loaded_q   <= loaded_d;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	sequence s_clk_low;
		!prog_clk [*4] ##1 prog_clk;
	endsequence
	sequence s_upd_pulse;
		(!update_n && !chip_sel_n) [*4] ##1 update_n;
	endsequence
	property p_clk_half;
		$fell(prog_clk) |-> s_clk_low;
	endproperty
	a_clk_half: assert property (p_clk_half) else $error("link clock low phase wrong");
	property p_bit_hold;
		!prog_clk && !chip_sel_n |-> $stable(data_in);
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("serial bit moved while clock low");
	property p_upd_high;
		$fell(prog_clk) && !chip_sel_n |-> update_n;
	endproperty
	a_upd_high: assert property (p_upd_high) else $error("update low during a load edge");
	property p_par_setup;
		$fell(prog_clk) && load_mode_select && !chip_sel_n |-> $stable(output_address) && $stable(slot_data);
	endproperty
	a_par_setup: assert property (p_par_setup) else $error("address or data moved at edge");
	property p_count;
		$rose(chip_sel_n) && falls_q != 12'h000 |->
			falls_q == ($past(load_mode_select) ? 12'h001 : 12'(WORD_W * CHAIN_LEN));
	endproperty
	a_count: assert property (p_count) else $error("wrong number of load edges in frame");
	property p_upd_pulse;
		$fell(update_n) |-> s_upd_pulse;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse shape wrong");
	property p_no_early;
		!update_n && !chip_sel_n |-> &loaded_q;
	endproperty
	a_no_early: assert property (p_no_early) else $error("update before full load");
	property p_idle;
		chip_sel_n |-> prog_clk && update_n;
	endproperty
	a_idle: assert property (p_idle) else $error("link not idle while deselected");
	property p_mode_hold;
		!chip_sel_n && $past(!chip_sel_n) |-> $stable(load_mode_select);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed inside frame");
	property p_ripple;
		$changed(data_out) |-> since_q <= 3'h5;
	endproperty
	a_ripple: assert property (p_ripple) else $error("serial out moved without a load edge");
endmodule

// ==== bench/crosspoint_program_logic_tb.sv ====
// Purpose: Self-checking bench for controller and device joined over the link
// Assumes: One device in the chain, default link timing
// Notes:   Expected matrix is tracked from the words the bench writes
`timescale 1ns/100ps
module crosspoint_program_logic_tb;
	import xpt_pkg::*;
	logic                     clk_sys;
	logic                     resetn;
	logic [REG_AW-1:0]        addr;
	logic [31:0]              wdata;
	logic                     wr;
	logic                     rd;
	logic [31:0]              rdata;
	logic [NUM_OUT*SEL_W-1:0] out_select;
	logic [NUM_OUT-1:0]       out_enable;
	logic [WORD_W-1:0]        word_v;
	logic [WORD_W-1:0]        exp_mat;
	logic [31:0]              rd_v;
	logic [ADDR_W-1:0]        a_v;
	logic [SLOT_W-1:0]        d_v;
	integer                   seed;
	integer                   bad_count;
	integer                   cmp_count;
	xpt_if link_if();
	xpt_host xpt_host_i (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .pins(link_if.host),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	xpt_dev xpt_dev_i (.clk_sys(clk_sys), .resetn(resetn), .clk_en(1'b1), .pins(link_if.dev),
		.out_select(out_select), .out_enable(out_enable));
	xpt_link_monitor #(.CHAIN_LEN(1)) xpt_link_monitor_i (.clk_sys(clk_sys), .resetn(resetn),
		.load_mode_select(link_if.load_mode_select), .chip_sel_n(link_if.chip_sel_n),
		.update_n(link_if.update_n), .prog_clk(link_if.prog_clk), .data_in(link_if.data_in),
		.data_out(link_if.data_out), .output_address(link_if.output_address),
		.slot_data(link_if.slot_data));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 rd_v = rdata;
	endtask
	// Polls status; a serial frame needs about 660 cycles
	task automatic wait_idle();
		int n;
		n = 0;
		rd_reg(REG_STATUS);
		while (rd_v[ST_BUSY] !== 1'b0 && n < 1000) begin
			rd_reg(REG_STATUS);
			n++;
		end
		if (n >= 1000) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, rd_v, 32'h0);
		end
		repeat (8) @(posedge clk_sys);
	endtask
	// Select bits of a disabled output are don't-care
	task automatic check_mat();
		for (int k = 0; k < NUM_OUT; k++) begin
			chk(32'(out_enable[k]), 32'(exp_mat[k*SLOT_W+EN_BIT]));
			if (exp_mat[k*SLOT_W+EN_BIT])
				chk(32'(out_select[k*SEL_W +: SEL_W]), 32'(exp_mat[k*SLOT_W +: SEL_W]));
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog, main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#(20000 * CLK_NS);
		bad_count++;
		give_verdict();
	end
	initial begin
		seed      = 45440;
		bad_count = 0;
		cmp_count = 0;
		resetn    = 1'b0;
		addr      = '0;
		wdata     = '0;
		wr        = 1'b0;
		rd        = 1'b0;
		exp_mat   = '0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(32'(out_enable), 32'h0);
		rd_reg(REG_CTRL);
		chk(rd_v, CTRL_RST);
		rd_reg(8'h20);
		chk(rd_v, 32'h0);
		// Shift register still holds power-up content, so this update must not land
		wr_reg(REG_CTRL, 32'h0C);
		repeat (12) @(posedge clk_sys);
		chk(32'(out_enable), 32'h0);
		$display("test power-up done");
		for (int i = 0; i < 4; i++) begin
			word_v = WORD_W'({$random(seed), $random(seed), $random(seed)});
			if (i == 0)
				word_v = '0;
			if (i == 1)
				word_v = '1;
			wr_reg(REG_DEV, 32'h0);
			wr_reg(REG_DATA0, word_v[31:0]);
			wr_reg(REG_DATA1, word_v[63:32]);
			wr_reg(REG_DATA2, {16'h0000, word_v[79:64]});
			wr_reg(REG_CTRL, 32'h19);
			if (i == 3) begin
				wr_reg(REG_PAR, 32'h1F0);
				wr_reg(REG_CTRL, 32'h0A);
			end
			wait_idle();
			exp_mat = word_v;
			check_mat();
		end
		rd_reg(REG_STATUS);
		chk(32'(rd_v[ST_LOADED]), 32'h1);
		$display("test serial done");
		// Edge slots first, then a random one; matrix must wait for update
		for (int i = 0; i < 3; i++) begin
			a_v = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : ADDR_W'($random(seed));
			d_v = SLOT_W'($random(seed));
			wr_reg(REG_PAR, 32'({d_v, a_v}));
			wr_reg(REG_CTRL, 32'h0A);
			wait_idle();
			word_v[a_v*SLOT_W +: SLOT_W] = d_v;
		end
		check_mat();
		wr_reg(REG_CTRL, 32'h0C);
		wait_idle();
		exp_mat = word_v;
		check_mat();
		$display("test parallel done");
		wr_reg(REG_CTRL, 32'h00);
		repeat (8) @(posedge clk_sys);
		chk(32'(out_enable), 32'h0);
		wr_reg(REG_CTRL, 32'h08);
		wr_reg(REG_CTRL, 32'h0C);
		wait_idle();
		check_mat();
		$display("test reset pin done");
		give_verdict();
	end
endmodule
